// ---- verilog/acr_regs.sv ----
// converter register block with two-wire serial slave front end
// assumes scl and sda arrive asynchronously; sample is on mclk
`timescale 1ns/1ps
`include "acr_regs_cfg.svh"
module acr_regs #(
   parameter acr_pkg::acr_cyc_t p_cyc_r0 = 20'(`ACR_MCLK_HZ / `ACR_RATE0_SPS), // cycles per sample, code 0
   parameter acr_pkg::acr_cyc_t p_cyc_r1 = 20'(`ACR_MCLK_HZ / `ACR_RATE1_SPS), // code 1
   parameter acr_pkg::acr_cyc_t p_cyc_r2 = 20'(`ACR_MCLK_HZ / `ACR_RATE2_SPS), // code 2
   parameter acr_pkg::acr_cyc_t p_cyc_r3 = 20'(`ACR_MCLK_HZ / `ACR_RATE3_SPS), // code 3
   parameter acr_pkg::acr_cyc_t p_cyc_r4 = 20'(`ACR_MCLK_HZ / `ACR_RATE4_SPS), // code 4
   parameter acr_pkg::acr_cyc_t p_cyc_r5 = 20'(`ACR_MCLK_HZ / `ACR_RATE5_SPS), // code 5
   parameter acr_pkg::acr_cyc_t p_cyc_r6 = 20'(`ACR_MCLK_HZ / `ACR_RATE6_SPS), // code 6
   parameter acr_pkg::acr_cyc_t p_cyc_r7 = 20'(`ACR_MCLK_HZ / `ACR_RATE7_SPS)  // code 7
) (
   input  wire logic         mclk,               // system clock, 125 MHz
   input  wire logic         rst_b,              // async reset, active low
   input  wire logic         scl,                // serial clock pin
   input  wire logic         sda_i,              // serial data pin level
   output logic              sda_o,              // serial data drive value
   output logic              sda_oe,             // serial data drive enable
   input  wire logic signed [13:0] sample,       // front end code, 12-bit lsb units
   output logic [2:0]        input_pair_select,  // input pairing to front end
   output logic [2:0]        gain_span_select,   // gain span to front end
   output logic              conv_active         // conversion in progress
);
   import acr_pkg::*;

   localparam acr_cyc_t RATE_TAB [0:7] = '{p_cyc_r0, p_cyc_r1, p_cyc_r2, p_cyc_r3,
                                          p_cyc_r4, p_cyc_r5, p_cyc_r6, p_cyc_r7};

   acr_conv_if cif ();

   // pin synchronisers and edge history
   logic         scl_s1, scl_s2, scl_s3;
   logic         sda_s1, sda_s2, sda_s3;

   acr_bus_st_t  st_q;
   acr_bus_st_t  next_q;
   logic [3:0]   cnt_q;
   logic [7:0]   sh_q;
   logic         ack_q;
   logic [1:0]   ptr_q;
   logic [7:0]   msb_q;
   logic [15:0]  rd_word_q;
   logic         byte_sel_q;
   logic         oe_q;
   logic         sda_o_q;
   logic [14:0]  cfg_q;
   logic [15:0]  result_q;
   logic         start_q;
   logic         busy_q;

   // bus event decode
   wire          scl_rise  = scl_s2 & ~scl_s3;
   wire          scl_fall  = ~scl_s2 & scl_s3;
   wire          start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   wire          stop_det  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
   wire          rx_state  = (st_q == ACR_ADDR) | (st_q == ACR_PTR) | (st_q == ACR_WMSB) | (st_q == ACR_WLSB);
   wire          byte_full = (cnt_q == 4'h8);
   wire [7:0]    sh_in     = {sh_q[6:0], sda_s2};
   wire          addr_hit  = (sh_q[7:1] == `ACR_SLAVE_ADDR);

   // read data path
   wire [7:0]    tx_byte   = byte_sel_q ? rd_word_q[7:0] : rd_word_q[15:8];
   wire [7:0]    tx_next   = byte_sel_q ? rd_word_q[15:8] : rd_word_q[7:0];
   wire [2:0]    tx_idx    = 3'h7 - cnt_q[2:0];
   wire          tx_bit    = tx_byte[tx_idx];
   wire          idle_flag = ~busy_q;                                              // [RL8]
   wire [15:0]   cfg_view  = {idle_flag, cfg_q};
   wire [15:0]   rd_mux    = (ptr_q == `ACR_PTR_RESULT) ? result_q :               // [RL4]
                             (ptr_q == `ACR_PTR_CONFIG) ? cfg_view : 16'h0000;     // [RL5]

   // register write path, committed at end of second data byte
   wire [15:0]   wr_word   = {msb_q, sh_q};                                        // [RL13]
   wire          wr_commit = scl_fall & ~ack_q & byte_full & (st_q == ACR_WLSB);
   wire          cfg_wr    = wr_commit & (ptr_q == `ACR_PTR_CONFIG);               // [RL16]
   wire          os_launch = cfg_wr & wr_word[`ACR_OS_BIT] & ~busy_q;              // [RL6] [RL7]

   assign cif.start      = start_q;
   assign cif.continuous = ~cfg_q[`ACR_MODE_BIT];                                  // [RL11]
   assign cif.period     = RATE_TAB[cfg_q[`ACR_DR_HI:`ACR_DR_LO]];                 // [RL12]
   assign cif.sample     = sample;

   assign sda_o             = sda_o_q;
   assign sda_oe            = oe_q;
   assign input_pair_select = cfg_q[`ACR_MUX_HI:`ACR_MUX_LO];                      // [RL9]
   assign gain_span_select  = cfg_q[`ACR_PGA_HI:`ACR_PGA_LO];                      // [RL10]
   assign conv_active       = busy_q;

   acr_conv_seq u_seq (
      .mclk  (mclk),
      .rst_b (rst_b),
      .cif   (cif)
   );

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_s3 <= 1'b1;
      end
      else
      begin
         scl_s1 <= scl;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         sda_s1 <= sda_i;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
      end
   end

   // configuration, start pulse and busy mirror
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cfg_q   <= 15'(`ACR_CONFIG_RST);
         start_q <= 1'b0;
         busy_q  <= 1'b0;
      end
      else
      begin
         start_q <= os_launch;                                                     // [RL7]
         busy_q  <= cif.busy | os_launch;
         if (cfg_wr)
            cfg_q <= wr_word[14:0];                                                // [RL5]
      end
   end

   // result register, cleared at reset and only replaced by conversions
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         result_q <= `ACR_RESULT_RST;                                              // [RL2] [RL4]
      else if (cif.done)
         result_q <= {cif.result, `ACR_RES_PAD};                                   // [RL1] [RL3] [RL15]
   end

   // serial slave sequencing
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_q       <= ACR_IDLE;
         next_q     <= ACR_IDLE;
         cnt_q      <= 4'h0;
         sh_q       <= 8'h00;
         ack_q      <= 1'b0;
         ptr_q      <= `ACR_PTR_RESULT;
         msb_q      <= 8'h00;
         rd_word_q  <= 16'h0000;
         byte_sel_q <= 1'b0;
         oe_q       <= 1'b0;
         sda_o_q    <= 1'b0;
      end
      else if (start_det)
      begin
         st_q  <= ACR_ADDR;
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
         oe_q  <= 1'b0;
      end
      else if (stop_det)
      begin
         st_q  <= ACR_IDLE;
         ack_q <= 1'b0;
         oe_q  <= 1'b0;
      end
      else if (scl_rise)
      begin
         if (rx_state & ~byte_full)
         begin
            sh_q  <= sh_in;
            cnt_q <= cnt_q + 4'h1;
         end
         else if (st_q == ACR_RD)
         begin
            cnt_q <= cnt_q + 4'h1;
            // master leaves data high on its ack slot to end the read
            if (byte_full & sda_s2)
               st_q <= ACR_IDLE;
         end
      end
      else if (scl_fall)
      begin
         if (ack_q)
         begin
            ack_q <= 1'b0;
            cnt_q <= 4'h0;
            st_q  <= next_q;
            oe_q  <= (next_q == ACR_RD) & ~tx_byte[7];
         end
         else if (rx_state & byte_full)
         begin
            case (st_q)
               ACR_ADDR:
                  if (addr_hit)
                  begin
                     ack_q      <= 1'b1;
                     oe_q       <= 1'b1;
                     next_q     <= sh_q[0] ? ACR_RD : ACR_PTR;
                     rd_word_q  <= rd_mux;
                     byte_sel_q <= 1'b0;
                  end
                  else
                     st_q <= ACR_IDLE;
               ACR_PTR:
               begin
                  ptr_q  <= sh_q[1:0];                                             // [RL13]
                  ack_q  <= 1'b1;
                  oe_q   <= 1'b1;
                  next_q <= ACR_WMSB;
               end
               ACR_WMSB:
               begin
                  msb_q  <= sh_q;                                                  // [RL13]
                  ack_q  <= 1'b1;
                  oe_q   <= 1'b1;
                  next_q <= ACR_WLSB;
               end
               ACR_WLSB:
               begin
                  ack_q  <= 1'b1;
                  oe_q   <= 1'b1;
                  next_q <= ACR_DONE;
               end
               default:
                  st_q <= ACR_IDLE;
            endcase
         end
         else if (st_q == ACR_RD)
         begin
            if (cnt_q < 4'h8)
               oe_q <= ~tx_bit;
            else if (byte_full)
               oe_q <= 1'b0;
            else
            begin
               byte_sel_q <= ~byte_sel_q;
               cnt_q      <= 4'h0;
               oe_q       <= ~tx_next[7];
            end
         end
      end
   end
endmodule // acr_regs

// ---- verilog/acr_regs_cfg.svh ----
// constants for the converter result and configuration registers
// assumes a 125 MHz mclk and an externally supplied signed sample
//
// Contract
// RL1: result is signed 12-bit, bits 15:4
// RL2: result stays zero until first conversion
// RL3: result low four bits always read zero
// RL4: pointer zero selects result; reset clears it
// RL5: pointer one selects configuration; reset 8583h
// RL6: start bit accepted only when not converting
// RL7: one launches single conversion; zero ignored
// RL8: start bit reads zero busy, one idle
// RL9: bits 14:12 select input pair
// RL10: bits 11:9 select full-scale span
// RL11: bit 8: zero continuous, one single-shot
// RL12: bits 7:5 select sample rate
// RL13: pointer byte, then data MSB first
// RL14: result saturates at 7FF0h and 8000h
// RL15: single-shot end: update, power down, idle
// RL16: continuous repeats; result writes ignored
`ifndef ACR_REGS_CFG_SVH
`define ACR_REGS_CFG_SVH

`define ACR_PTR_RESULT   2'h0
`define ACR_PTR_CONFIG   2'h1
`define ACR_RESULT_RST   16'h0000
`define ACR_CONFIG_RST   16'h8583
`define ACR_OS_BIT       15
`define ACR_MUX_HI       14
`define ACR_MUX_LO       12
`define ACR_PGA_HI       11
`define ACR_PGA_LO       9
`define ACR_MODE_BIT     8
`define ACR_DR_HI        7
`define ACR_DR_LO        5
`define ACR_RES_PAD      4'h0
`define ACR_SLAVE_ADDR   7'h48
`define ACR_SAT_POS      12'h7FF
`define ACR_SAT_NEG      12'h800
`define ACR_MCLK_HZ      125000000
`define ACR_RATE0_SPS    128
`define ACR_RATE1_SPS    250
`define ACR_RATE2_SPS    490
`define ACR_RATE3_SPS    920
`define ACR_RATE4_SPS    1600
`define ACR_RATE5_SPS    2400
`define ACR_RATE6_SPS    3300
`define ACR_RATE7_SPS    3300

`endif

// ---- verilog/acr_pkg.sv ----
// types shared by the register block and the conversion sequencer
// assumes acr_regs_cfg.svh supplies the numeric constants
package acr_pkg;
   typedef logic [19:0] acr_cyc_t;
   typedef enum {ACR_IDLE, ACR_ADDR, ACR_PTR, ACR_WMSB, ACR_WLSB, ACR_DONE, ACR_RD} acr_bus_st_t;
   typedef enum {ACR_SEQ_IDLE, ACR_SEQ_CONV} acr_seq_st_t;
endpackage

// ---- verilog/acr_conv_if.sv ----
// link between register block and conversion sequencer
// assumes both ends run on mclk
`timescale 1ns/1ps
interface acr_conv_if;
   logic                start;
   logic                continuous;
   acr_pkg::acr_cyc_t   period;
   logic signed [13:0]  sample;
   logic                busy;
   logic                done;
   logic [11:0]         result;
   modport ctl (output start, output continuous, output period, output sample,
                input busy, input done, input result);
   modport seq (input start, input continuous, input period, input sample,
                output busy, output done, output result);
endinterface

// ---- verilog/acr_conv_seq.sv ----
// conversion sequencer: paces conversions and saturates the sample
// assumes sample is valid in the cycle the period expires
`timescale 1ns/1ps
`include "acr_regs_cfg.svh"
module acr_conv_seq (
   input wire logic  mclk,    // system clock
   input wire logic  rst_b,   // async reset, active low
   acr_conv_if.seq   cif      // control and result link
);
   import acr_pkg::*;

   acr_seq_st_t  st_q;
   acr_cyc_t     cnt_q;
   logic         busy_q;
   logic         done_q;
   logic [11:0]  res_q;

   wire          sat_hi  = (cif.sample > $signed(14'sh07FF));
   wire          sat_lo  = (cif.sample < $signed(14'sh3800));
   wire [11:0]   sat_val = sat_hi ? `ACR_SAT_POS : (sat_lo ? `ACR_SAT_NEG : cif.sample[11:0]); // [RL14]
   wire          expire  = (cnt_q == 20'h00000);
   wire          launch  = cif.start | cif.continuous;

   assign cif.busy   = busy_q;
   assign cif.done   = done_q;
   assign cif.result = res_q;

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_q   <= ACR_SEQ_IDLE;
         cnt_q  <= 20'h00000;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         res_q  <= 12'h000;
      end
      else
      begin
         done_q <= 1'b0;
         case (st_q)
            ACR_SEQ_IDLE:
               if (launch)
               begin
                  st_q   <= ACR_SEQ_CONV;
                  cnt_q  <= cif.period - 20'h00001; // [RL12]
                  busy_q <= 1'b1;
               end
            ACR_SEQ_CONV:
               if (expire)
               begin
                  res_q  <= sat_val;
                  done_q <= 1'b1;
                  if (cif.continuous)
                     cnt_q <= cif.period - 20'h00001; // [RL16]
                  else
                  begin
                     st_q   <= ACR_SEQ_IDLE; // [RL15]
                     busy_q <= 1'b0;
                  end
               end
               else
                  cnt_q <= cnt_q - 20'h00001;
            default:
               st_q <= ACR_SEQ_IDLE;
         endcase
      end
   end
endmodule // acr_conv_seq

// ---- tb/acr_regs_chk.sv ----
// pin-level checks for the converter register block
// assumes it is bound onto acr_regs and scl is sampled on mclk
`timescale 1ns/1ps
module acr_regs_chk (
   input wire logic               mclk,              // system clock
   input wire logic               rst_b,             // async reset, active low
   input wire logic               scl,               // serial clock pin
   input wire logic               sda_i,             // serial data level
   input wire logic               sda_o,             // data drive value
   input wire logic               sda_oe,            // data drive enable
   input wire logic signed [13:0] sample,            // front end code
   input wire logic [2:0]         input_pair_select, // input pairing
   input wire logic [2:0]         gain_span_select,  // gain span
   input wire logic               conv_active        // conversion running
);
   logic       scl_q;
   logic [3:0] since_q;
   logic [3:0] since_d;
   // cycles since the serial clock was last seen falling
   assign since_d = (scl_q && !scl) ? 4'h0 : ((since_q == 4'hF) ? since_q : since_q + 4'h1);
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         scl_q   <= 1'b1;
         since_q <= 4'hF;
      end
      else
      begin
         scl_q   <= scl;
         since_q <= since_d;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_sda_drives_low: assert property (sda_o == 1'b0)
      else $error("data drive value not low");
   a_oe_moves_low: assert property ($changed(sda_oe) |-> !scl)
      else $error("data enable moved while clock high");
   a_oe_holds_high: assert property (scl && $past(scl) |-> $stable(sda_oe))
      else $error("data enable unstable in clock high");
   a_reset_cfg_fields: assert property ($rose(rst_b) |-> gain_span_select == 3'h2 && input_pair_select == 3'h0)
      else $error("config fields not at reset value");
   a_reset_no_conv: assert property ($rose(rst_b) |-> !conv_active && !sda_oe)
      else $error("activity right after reset");
   a_pair_after_fall: assert property ($changed(input_pair_select) |-> since_q <= 4'h7)
      else $error("input pair changed away from a byte end");
   a_gain_after_fall: assert property ($changed(gain_span_select) |-> since_q <= 4'h7)
      else $error("gain span changed away from a byte end");
   a_conv_min_len: assert property ($rose(conv_active) |-> conv_active [*8])
      else $error("conversion ended too soon");
   c_conv_start: cover property ($rose(conv_active));
endmodule // acr_regs_chk

bind acr_regs acr_regs_chk u_chk (
   .mclk(mclk), .rst_b(rst_b), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .sample(sample),
   .input_pair_select(input_pair_select), .gain_span_select(gain_span_select), .conv_active(conv_active)
);

// ---- tb/acr_i2c_mst.sv ----
// serial bus master model, open-drain data, clock idles high
// assumes the bench resolves data as a wired-and with a pull-up
`timescale 1ns/1ps
module acr_i2c_mst #(
   parameter logic [6:0] p_addr = 7'h48  // device address
) (
   output logic     scl,   // serial clock
   output logic     sda_m, // data drive, 1 = released
   input wire logic sda    // resolved data wire
);
   initial
   begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic bitx(input logic b, output logic r);
      #20 sda_m = b;
      #20 scl = 1'b1;
      #20 r = sda;
      #20 scl = 1'b0;
   endtask
   task automatic start();
      #20 sda_m = 1'b1;
      #20 scl = 1'b1;
      #20 sda_m = 1'b0;
      #20 scl = 1'b0;
   endtask
   task automatic stop();
      #20 sda_m = 1'b0;
      #20 scl = 1'b1;
      #20 sda_m = 1'b1;
      #20;
   endtask
   task automatic xbyte(input logic [7:0] w, input logic ack_in, output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--)
         bitx(w[i], r[i]);
      bitx(ack_in, ack);
   endtask
   task automatic wr_ptr(input logic [6:0] a, input logic [1:0] ptr, output logic nack);
      logic [7:0] r;
      logic       k;
      start();
      xbyte({a, 1'b0}, 1'b1, r, nack);
      xbyte({6'h00, ptr}, 1'b1, r, k);
   endtask
   task automatic wr(input logic [1:0] ptr, input logic [15:0] d);
      logic [7:0] r;
      logic       k;
      wr_ptr(p_addr, ptr, k);
      xbyte(d[15:8], 1'b1, r, k);
      xbyte(d[7:0], 1'b1, r, k);
      stop();
   endtask
   task automatic rd(input logic [1:0] ptr, output logic [15:0] d);
      logic [7:0] r;
      logic       k;
      wr_ptr(p_addr, ptr, k);
      start();
      xbyte({p_addr, 1'b1}, 1'b1, r, k);
      xbyte(8'hFF, 1'b0, d[15:8], k);
      xbyte(8'hFF, 1'b1, d[7:0], k);
      stop();
   endtask
endmodule // acr_i2c_mst

// ---- tb/acr_regs_tb.sv ----
// self-checking bench for the converter register block
// assumes the serial master model and the bound checker
`timescale 1ns/1ps
module acr_regs_tb;
   import acr_pkg::*;
   logic               mclk;
   logic               rst_b;
   logic               scl;
   logic               sda_m;
   logic               sda_o;
   logic               sda_oe;
   logic               conv_active;
   logic               nack;
   wire logic          sda;
   logic signed [13:0] sample;
   logic [2:0]         input_pair_select;
   logic [2:0]         gain_span_select;
   logic [15:0]        rv;
   int                 mismatches = 0;
   int                 check_count = 0;
   int                 cycles = 0;
   logic signed [13:0] sat_in [3] = '{14'sd3000, -14'sd3000, -14'sd1};
   logic [15:0]        sat_exp [3] = '{16'h7FF0, 16'h8000, 16'hFFF0};
   // pull-up wired-and of both parties
   assign sda = sda_m & ~sda_oe;
   acr_regs #(.p_cyc_r0(20'd400), .p_cyc_r4(20'd2000)) uut (
      .mclk(mclk), .rst_b(rst_b), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .sample(sample),
      .input_pair_select(input_pair_select), .gain_span_select(gain_span_select), .conv_active(conv_active));
   acr_i2c_mst m (.scl(scl), .sda_m(sda_m), .sda(sda));
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 3000 && conv_active !== 1'b0; i++)
         @(posedge mclk);
      check(16'(conv_active), 16'h0);
   endtask
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         mismatches++;
         report_and_stop();
      end
   end
   initial
   begin
      rst_b = 1'b0;
      sample = 14'sd0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      check(16'(gain_span_select), 16'h2);
      check(16'(input_pair_select), 16'h0);
      m.rd(2'h1, rv);
      check(rv, 16'h8583);
      m.rd(2'h0, rv);
      check(rv, 16'h0000);
      m.wr(2'h0, 16'h1234);
      m.rd(2'h0, rv);
      check(rv, 16'h0000);
      m.wr_ptr(7'h49, 2'h1, nack);
      m.stop();
      check(16'(nack), 16'h1);
      @(posedge mclk) sample <= 14'sd100;
      m.wr(2'h1, 16'hC383);
      check(16'(conv_active), 16'h1);
      check(16'(input_pair_select), 16'h4);
      check(16'(gain_span_select), 16'h1);
      m.rd(2'h1, rv);
      check(rv, 16'h4383);
      // start written again while busy must not relaunch
      m.wr(2'h1, 16'hD383);
      wait_idle();
      repeat (50) @(posedge mclk);
      check(16'(conv_active), 16'h0);
      m.rd(2'h0, rv);
      check(rv, 16'h0640);
      m.rd(2'h1, rv);
      check(rv, 16'hD383);
      for (int i = 0; i < 3; i++)
      begin
         @(posedge mclk) sample <= sat_in[i];
         m.wr(2'h1, 16'h8383);
         wait_idle();
         m.rd(2'h0, rv);
         check(rv, sat_exp[i]);
      end
      m.wr(2'h1, 16'h0383);
      repeat (50) @(posedge mclk);
      check(16'(conv_active), 16'h0);
      @(posedge mclk) sample <= 14'sd5;
      m.wr(2'h1, 16'h0203);
      repeat (1000) @(posedge mclk);
      m.rd(2'h0, rv);
      check(rv, 16'h0050);
      @(posedge mclk) sample <= 14'sd7;
      repeat (1000) @(posedge mclk);
      m.rd(2'h0, rv);
      check(rv, 16'h0070);
      m.wr(2'h1, 16'h0383);
      wait_idle();
      @(posedge mclk) rst_b <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      m.rd(2'h1, rv);
      check(rv, 16'h8583);
      m.rd(2'h0, rv);
      check(rv, 16'h0000);
      report_and_stop();
   end
endmodule // acr_regs_tb
